// ### core/bridge_misc_config_pkg.sv
// Package for the bridge miscellaneous configuration register bank.
// Assumes a byte-addressed register port with 32-bit read and write data.
package bridge_misc_config_pkg;

    // ******************************************************************
    // Register port geometry
    // ******************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ******************************************************************
    // Offsets
    // ******************************************************************
    localparam logic [7:0] OFS_PIN_EVENT_STATUS = 8'h40;
    localparam logic [7:0] OFS_PIN_FUNCTION_SELECT = 8'h44;
    localparam logic [7:0] OFS_PIN_INTERRUPT_TRIGGER_TYPE = 8'h48;
    localparam logic [7:0] OFS_MISC_CONTROL_STATUS = 8'h4c;
    localparam logic [7:0] OFS_TEST_DIAGNOSTIC_CONTROL = 8'h4f;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    // Pin function select and trigger type share bit positions
    localparam int BIT_PIN5 = 5;
    localparam int BIT_PIN4 = 4;
    localparam int BIT_PIN3 = 3;
    localparam int BIT_PIN2 = 2;
    // Event status
    localparam int BIT_PIN3_EVENT_FLAG = 28;
    localparam int BIT_PIN2_EVENT_FLAG = 27;
    // Misc control and status
    localparam int BIT_EEPROM_PRESENT = 15;
    localparam int BIT_EEPROM_ERROR = 14;
    localparam int BIT_EEPROM_BUSY = 13;
    localparam int BIT_HANDLE_SWITCH_STATE = 8;
    localparam int LOADED_W = 6;
    // Diagnostic
    localparam int BIT_ID_ALL_ONES = 7;
    localparam int BIT_DELAYED_TXN_DISABLE = 4;
    localparam int BIT_LATENCY_EXTEND = 3;
    localparam int BIT_ERROR_TIMER_DISABLE = 1;
    localparam int BIT_STATE_VECTOR_OUT = 0;

    // ******************************************************************
    // Reset values and writable masks
    // ******************************************************************
    localparam logic [1:0] TRIGGER_TYPE_RESET = 2'h0;
    localparam logic [1:0] PIN_SELECT_RESET = 2'h0;
    localparam logic [5:0] MISC_LOADED_RESET = 6'h0f;
    localparam logic [7:0] DIAG_RESET = 8'h00;
    localparam logic [7:0] DIAG_WRITE_MASK = 8'h9b;

    // ******************************************************************
    // Target latency limits in bus clocks
    // ******************************************************************
    localparam logic [6:0] TARGET_LATENCY_NORMAL = 7'h10;
    localparam logic [6:0] TARGET_LATENCY_EXTENDED = 7'h40;

endpackage

// ### core/bridge_misc_config_regs.sv
// Miscellaneous configuration, status and diagnostic register bank of the
// bridge, with the pin 2 and pin 3 event detectors.
// Assumes the register master and the EEPROM loader share core_clk_i, while
// the pin and handle switch inputs arrive unsynchronised.
//
// Notes on behaviour
// (RQ1) Pin 3 type: low level or change
// (RQ2) Pin 2 type: low level or change
// (RQ3) Trigger register: only bits 3,2 writable
// (RQ4) Bit 15 shows EEPROM detected
// (RQ5) Bit 14 error sticky, write one clears
// (RQ6) Bit 13 shows EEPROM interface busy
// (RQ7) Bit 8 shows handle switch level
// (RQ8) Bit 5 enables expansion bus
// (RQ9) Bit 4 selects power management layout
// (RQ10) Bit 3 enables hot swap, default on
// (RQ11) Bit 2 locks cold wake support bit
// (RQ12) Bit 1 enables posted writes, default on
// (RQ13) Bit 0 write-protects subsystem IDs
// (RQ14) Misc word resets 000f, reserved zero
// (RQ15) Diag bit 7 forces ID reads ones
// (RQ16) Diag bit 4 disables delayed transactions
// (RQ17) Diag bit 3 stretches latency 16 to 64
// (RQ18) Diag bit 1 disables error timer
// (RQ19) Diag bit 0 routes state vectors out
// (RQ20) Software leaves diagnostic register alone normally
// (RQ21) Diag resets 00, reserved bits zero
// (RQ22) No pin event unless pin selected interrupt
// (RQ23) Expansion enable turns pins 5,4 strobes
// (RQ24) Change detected from successive synchronised samples
//
// Strobed register access was left to the implementer.
module bridge_misc_config_regs (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [bridge_misc_config_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [bridge_misc_config_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [bridge_misc_config_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic eeprom_present_i,
    input wire logic eeprom_error_i,
    input wire logic eeprom_busy_i,
    input wire logic eeprom_load_i,
    input wire logic [bridge_misc_config_pkg::LOADED_W-1:0] eeprom_load_data_i,
    input wire logic handle_switch_input_i,
    input wire logic pin2_input_i,
    input wire logic pin3_input_i,
    output logic pin2_event_flag_o,
    output logic pin3_event_flag_o,
    output logic expansion_read_strobe_sel_o,
    output logic expansion_write_strobe_sel_o,
    output logic expansion_bus_enable_o,
    output logic pm_rev_select_o,
    output logic hot_swap_enable_o,
    output logic cold_wake_lock_o,
    output logic posted_write_enable_o,
    output logic subsys_id_write_protect_o,
    output logic id_all_ones_o,
    output logic delayed_txn_disable_o,
    output logic latency_extend_o,
    output logic [6:0] target_latency_limit_o,
    output logic error_timer_disable_o,
    output logic state_vector_out_o
);

    // ******************************************************************
    // State
    // ******************************************************************
    typedef struct packed {
        logic [2:0] p2_sync;
        logic [2:0] p3_sync;
        logic [2:0] hs_sync;
        logic p2_val;
        logic p3_val;
        logic hs_val;
        logic [1:0] pin_sel;
        logic [1:0] trig;
        logic [1:0] evt;
        logic err;
        logic [5:0] loaded;
        logic [7:0] diag;
        logic [6:0] latency;
        logic [31:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Sampled value moves only once the second and third stages agree,
    // which rejects a single-cycle glitch at the cost of one more cycle.
    function automatic logic filtered(input logic [2:0] s, input logic cur);
        filtered = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input logic wr, input logic [bridge_misc_config_pkg::ADDR_W-1:0] addr,
                                    input logic [bridge_misc_config_pkg::ADDR_W-1:0] ofs);
        wr_hit = wr && (addr == ofs);
    endfunction

    // Event condition for one pin
    function automatic logic pin_hit(input logic sel, input logic trig, input logic cur, input logic nxt);
        pin_hit = sel & (trig ? (cur != nxt) : ~nxt);
    endfunction

    // ******************************************************************
    // Next state
    // ******************************************************************
    always_comb begin
        logic hit2;
        logic hit3;
        logic wr_evt;
        logic wr_sel;
        logic wr_trig;
        logic wr_misc;
        logic wr_diag;
        logic [31:0] rd;
        hit2 = 1'b0;
        hit3 = 1'b0;
        rd = 32'h0000_0000;
        state_next = state_reg;

        wr_evt = wr_hit(reg_wr_i, reg_addr_i, bridge_misc_config_pkg::OFS_PIN_EVENT_STATUS);
        wr_sel = wr_hit(reg_wr_i, reg_addr_i, bridge_misc_config_pkg::OFS_PIN_FUNCTION_SELECT);
        wr_trig = wr_hit(reg_wr_i, reg_addr_i, bridge_misc_config_pkg::OFS_PIN_INTERRUPT_TRIGGER_TYPE);
        wr_misc = wr_hit(reg_wr_i, reg_addr_i, bridge_misc_config_pkg::OFS_MISC_CONTROL_STATUS);
        wr_diag = wr_hit(reg_wr_i, reg_addr_i, bridge_misc_config_pkg::OFS_TEST_DIAGNOSTIC_CONTROL);

        // Pin synchronisers; stage 0 feeds only stage 1
        state_next.p2_sync = {state_reg.p2_sync[1:0], pin2_input_i};
        state_next.p3_sync = {state_reg.p3_sync[1:0], pin3_input_i};
        state_next.hs_sync = {state_reg.hs_sync[1:0], handle_switch_input_i};
        // (RQ24) Successive sample compare
        state_next.p2_val = filtered(state_reg.p2_sync, state_reg.p2_val);
        state_next.p3_val = filtered(state_reg.p3_sync, state_reg.p3_val);
        state_next.hs_val = filtered(state_reg.hs_sync, state_reg.hs_val);

        // (RQ3) Only trigger bits writable
        if (wr_trig) begin
            state_next.trig = {reg_wdata_i[bridge_misc_config_pkg::BIT_PIN3],
                               reg_wdata_i[bridge_misc_config_pkg::BIT_PIN2]};
        end
        if (wr_sel) begin
            state_next.pin_sel = {reg_wdata_i[bridge_misc_config_pkg::BIT_PIN3],
                                  reg_wdata_i[bridge_misc_config_pkg::BIT_PIN2]};
        end

        // (RQ22) Event gated by select
        // (RQ1) Pin 3 trigger choice
        hit3 = pin_hit(state_reg.pin_sel[1], state_reg.trig[1], state_reg.p3_val, state_next.p3_val);
        // (RQ2) Pin 2 trigger choice
        hit2 = pin_hit(state_reg.pin_sel[0], state_reg.trig[0], state_reg.p2_val, state_next.p2_val);
        // Write one clears, but a new event in the same cycle wins
        if (wr_evt) begin
            state_next.evt = state_reg.evt & ~{reg_wdata_i[bridge_misc_config_pkg::BIT_PIN3_EVENT_FLAG],
                                               reg_wdata_i[bridge_misc_config_pkg::BIT_PIN2_EVENT_FLAG]};
        end
        state_next.evt = state_next.evt | {hit3, hit2};

        // (RQ5) Error sticky, write one clears, set wins
        if (wr_misc && reg_wdata_i[bridge_misc_config_pkg::BIT_EEPROM_ERROR]) begin
            state_next.err = 1'b0;
        end
        if (eeprom_error_i) begin
            state_next.err = 1'b1;
        end

        // (RQ8) Enables come from the EEPROM loader, not software
        if (eeprom_load_i) begin
            state_next.loaded = eeprom_load_data_i;
        end

        // (RQ21) Reserved diagnostic bits stay zero
        if (wr_diag) begin
            state_next.diag = reg_wdata_i[7:0] & bridge_misc_config_pkg::DIAG_WRITE_MASK;
        end
        // (RQ17) Latency limit choice
        state_next.latency = state_next.diag[bridge_misc_config_pkg::BIT_LATENCY_EXTEND]
                             ? bridge_misc_config_pkg::TARGET_LATENCY_EXTENDED
                             : bridge_misc_config_pkg::TARGET_LATENCY_NORMAL;

        // Read data is captured on the read strobe and is zero in every other cycle
        case (reg_addr_i)
            bridge_misc_config_pkg::OFS_PIN_EVENT_STATUS: begin
                rd[bridge_misc_config_pkg::BIT_PIN3_EVENT_FLAG] = state_reg.evt[1];
                rd[bridge_misc_config_pkg::BIT_PIN2_EVENT_FLAG] = state_reg.evt[0];
            end
            bridge_misc_config_pkg::OFS_PIN_FUNCTION_SELECT: begin
                // (RQ23) Strobe function follows enable
                rd[bridge_misc_config_pkg::BIT_PIN5] = state_reg.loaded[5];
                rd[bridge_misc_config_pkg::BIT_PIN4] = state_reg.loaded[5];
                rd[bridge_misc_config_pkg::BIT_PIN3] = state_reg.pin_sel[1];
                rd[bridge_misc_config_pkg::BIT_PIN2] = state_reg.pin_sel[0];
            end
            bridge_misc_config_pkg::OFS_PIN_INTERRUPT_TRIGGER_TYPE: begin
                rd[bridge_misc_config_pkg::BIT_PIN3] = state_reg.trig[1];
                rd[bridge_misc_config_pkg::BIT_PIN2] = state_reg.trig[0];
            end
            bridge_misc_config_pkg::OFS_MISC_CONTROL_STATUS: begin
                // (RQ4) Present flag live
                rd[bridge_misc_config_pkg::BIT_EEPROM_PRESENT] = eeprom_present_i;
                rd[bridge_misc_config_pkg::BIT_EEPROM_ERROR] = state_reg.err;
                // (RQ6) Busy flag live
                rd[bridge_misc_config_pkg::BIT_EEPROM_BUSY] = eeprom_busy_i;
                // (RQ7) Handle level
                rd[bridge_misc_config_pkg::BIT_HANDLE_SWITCH_STATE] = state_reg.hs_val;
                // (RQ14) Reserved bits zero
                rd[bridge_misc_config_pkg::LOADED_W-1:0] = state_reg.loaded;
            end
            bridge_misc_config_pkg::OFS_TEST_DIAGNOSTIC_CONTROL: begin
                rd[7:0] = state_reg.diag;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        state_next.rdata = reg_rd_i ? rd : 32'h0000_0000;
    end

    // ******************************************************************
    // Registers
    // ******************************************************************
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.trig <= bridge_misc_config_pkg::TRIGGER_TYPE_RESET;
            state_reg.pin_sel <= bridge_misc_config_pkg::PIN_SELECT_RESET;
            // (RQ14) Misc reset value
            state_reg.loaded <= bridge_misc_config_pkg::MISC_LOADED_RESET;
            state_reg.diag <= bridge_misc_config_pkg::DIAG_RESET;
            state_reg.latency <= bridge_misc_config_pkg::TARGET_LATENCY_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // ******************************************************************
    // Outputs, each a flop
    // ******************************************************************
    assign reg_rdata_o = state_reg.rdata;
    assign pin2_event_flag_o = state_reg.evt[0];
    assign pin3_event_flag_o = state_reg.evt[1];
    // (RQ23) Pins 5,4 strobe function
    assign expansion_read_strobe_sel_o = state_reg.loaded[5];
    assign expansion_write_strobe_sel_o = state_reg.loaded[5];
    assign expansion_bus_enable_o = state_reg.loaded[5];
    // (RQ9) Layout select
    assign pm_rev_select_o = state_reg.loaded[4];
    // (RQ10) Hot swap enable
    assign hot_swap_enable_o = state_reg.loaded[3];
    // (RQ11) Cold wake lock
    assign cold_wake_lock_o = state_reg.loaded[2];
    // (RQ12) Posted write gate
    assign posted_write_enable_o = state_reg.loaded[1];
    // (RQ13) Subsystem ID protect
    assign subsys_id_write_protect_o = state_reg.loaded[0];
    // (RQ15) ID reads forced ones
    assign id_all_ones_o = state_reg.diag[bridge_misc_config_pkg::BIT_ID_ALL_ONES];
    // (RQ16) Delayed transaction disable
    assign delayed_txn_disable_o = state_reg.diag[bridge_misc_config_pkg::BIT_DELAYED_TXN_DISABLE];
    assign latency_extend_o = state_reg.diag[bridge_misc_config_pkg::BIT_LATENCY_EXTEND];
    assign target_latency_limit_o = state_reg.latency;
    // (RQ18) Error timer disable
    assign error_timer_disable_o = state_reg.diag[bridge_misc_config_pkg::BIT_ERROR_TIMER_DISABLE];
    // (RQ19) State vector routing
    assign state_vector_out_o = state_reg.diag[bridge_misc_config_pkg::BIT_STATE_VECTOR_OUT];

endmodule

// ### test/bridge_misc_config_props.sv
// Port-level checks for the misc configuration register bank.
// Assumes it is bound to the bank and sees only the bank's ports.
module bridge_misc_config_props (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic eeprom_present_i,
    input wire logic eeprom_busy_i,
    input wire logic eeprom_load_i,
    input wire logic [bridge_misc_config_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [bridge_misc_config_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic [bridge_misc_config_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic [bridge_misc_config_pkg::LOADED_W-1:0] eeprom_load_data_i,
    input wire logic expansion_read_strobe_sel_o,
    input wire logic expansion_write_strobe_sel_o,
    input wire logic expansion_bus_enable_o,
    input wire logic pm_rev_select_o,
    input wire logic hot_swap_enable_o,
    input wire logic cold_wake_lock_o,
    input wire logic posted_write_enable_o,
    input wire logic subsys_id_write_protect_o,
    input wire logic id_all_ones_o,
    input wire logic delayed_txn_disable_o,
    input wire logic latency_extend_o,
    input wire logic error_timer_disable_o,
    input wire logic state_vector_out_o,
    input wire logic [6:0] target_latency_limit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] misc_w;
    logic [7:0] diag_w;
    logic diag_wr;
    assign misc_w = {expansion_bus_enable_o, pm_rev_select_o, hot_swap_enable_o, cold_wake_lock_o,
        posted_write_enable_o, subsys_id_write_protect_o};
    assign diag_w = {id_all_ones_o, 2'h0, delayed_txn_disable_o, latency_extend_o, 1'h0, error_timer_disable_o,
        state_vector_out_o};
    assign diag_wr = reg_wr_i && reg_addr_i == 8'h4f;
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_lat; target_latency_limit_o == (latency_extend_o ? 7'h40 : 7'h10); endproperty
    a_lat: assert property (p_lat) else $error("latency limit wrong");
    property p_strobe;
        {expansion_read_strobe_sel_o, expansion_write_strobe_sel_o} == {2{expansion_bus_enable_o}};
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe select wrong");
    property p_diag_wr; diag_wr |=> diag_w == ($past(reg_wdata_i[7:0]) & 8'h9b); endproperty
    a_diag_wr: assert property (p_diag_wr) else $error("diag write wrong");
    property p_diag_hold; !diag_wr |=> $stable(diag_w); endproperty
    a_diag_hold: assert property (p_diag_hold) else $error("diag changed unasked");
    property p_load; eeprom_load_i |=> misc_w == $past(eeprom_load_data_i); endproperty
    a_load: assert property (p_load) else $error("loaded bits wrong");
    property p_misc_hold; !eeprom_load_i |=> $stable(misc_w); endproperty
    a_misc_hold: assert property (p_misc_hold) else $error("loaded bits changed");
    property p_rd_trig;
        reg_rd_i && reg_addr_i == 8'h48 |=> reg_rdata_o[31:4] == 0 && reg_rdata_o[1:0] == 0;
    endproperty
    a_rd_trig: assert property (p_rd_trig) else $error("trigger reserved bits set");
    property p_rd_diag; reg_rd_i && reg_addr_i == 8'h4f |=> reg_rdata_o == {24'h0, $past(diag_w)}; endproperty
    a_rd_diag: assert property (p_rd_diag) else $error("diag read wrong");
    property p_rd_misc;
        reg_rd_i && reg_addr_i == 8'h4c |=> reg_rdata_o[31:16] == 0 && reg_rdata_o[12:9] == 0 &&
            reg_rdata_o[15] == $past(eeprom_present_i) && reg_rdata_o[13] == $past(eeprom_busy_i) &&
            reg_rdata_o[7:0] == {2'h0, $past(misc_w)};
    endproperty
    a_rd_misc: assert property (p_rd_misc) else $error("misc read wrong");
endmodule

bind bridge_misc_config_regs bridge_misc_config_props u_props (.core_clk_i, .rst_i, .reg_wr_i, .reg_rd_i,
    .eeprom_present_i, .eeprom_busy_i, .eeprom_load_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .eeprom_load_data_i, .expansion_read_strobe_sel_o, .expansion_write_strobe_sel_o, .expansion_bus_enable_o,
    .pm_rev_select_o, .hot_swap_enable_o, .cold_wake_lock_o, .posted_write_enable_o,
    .subsys_id_write_protect_o, .id_all_ones_o, .delayed_txn_disable_o, .latency_extend_o,
    .error_timer_disable_o, .state_vector_out_o, .target_latency_limit_o);

// ### test/cfg_host_model.sv
// Register master standing in for the configuration host.
// Assumes one clock shared with the bank; strobes are single cycles.
module cfg_host_model (
    input wire logic core_clk_i,
    input wire logic [31:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
        // Released data shows the inverse so a stale value never matches
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
    endtask
endmodule

// ### test/tb_top.sv
// Self-checking bench for the misc configuration register bank.
// Assumes the host model owns the register port; loader and pins are driven here.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rv, d;
    logic reg_wr_i, reg_rd_i, ld, present, busy, err, handle, pin2, pin3, f2, f3;
    logic [5:0] misc, ldata;
    logic [4:0] diag;
    logic [1:0] sel;
    logic [6:0] lat;
    int errors = 0;
    int num_checks = 0;
    int seed = 94994;
    always #25 core_clk_i = ~core_clk_i;
    cfg_host_model host (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
    bridge_misc_config_regs uut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .eeprom_present_i(present), .eeprom_error_i(err), .eeprom_busy_i(busy),
        .eeprom_load_i(ld), .eeprom_load_data_i(ldata), .handle_switch_input_i(handle),
        .pin2_input_i(pin2), .pin3_input_i(pin3), .pin2_event_flag_o(f2), .pin3_event_flag_o(f3),
        .expansion_read_strobe_sel_o(sel[1]), .expansion_write_strobe_sel_o(sel[0]),
        .expansion_bus_enable_o(misc[5]), .pm_rev_select_o(misc[4]), .hot_swap_enable_o(misc[3]),
        .cold_wake_lock_o(misc[2]), .posted_write_enable_o(misc[1]), .subsys_id_write_protect_o(misc[0]),
        .id_all_ones_o(diag[4]), .delayed_txn_disable_o(diag[3]), .latency_extend_o(diag[2]),
        .target_latency_limit_o(lat), .error_timer_disable_o(diag[1]), .state_vector_out_o(diag[0]));
    function automatic logic [31:0] misc_exp(input logic [5:0] l, input logic p, e, b, h);
        return {16'h0, p, e, b, 4'h0, h, 2'h0, l};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        errors++;
        conclude();
    end
    initial begin
        {ld, present, busy, err, handle, pin2, pin3, ldata} = '0;
        cyc(10);
        rst_i <= 1'b0;
        rdc(8'h48, 32'h0);
        rdc(8'h4c, 32'h0f);
        rdc(8'h4f, 32'h0);
        rdc(8'h50, 32'h0);
        chk(32'({misc, lat}), 32'({6'h0f, 7'h10}));
        // Random writes, with all-ones first as the corner case
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hffffffff : $random(seed);
            host.wr(8'h48, d);
            rdc(8'h48, d & 32'h0c);
            host.wr(8'h4f, d);
            rdc(8'h4f, d & 32'h9b);
            chk(32'(diag), 32'({d[7], d[4], d[3], d[1], d[0]}));
            chk(32'(lat), d[3] ? 32'h40 : 32'h10);
            @(posedge core_clk_i);
            ldata <= d[13:8];
            ld <= 1'b1;
            @(posedge core_clk_i);
            ld <= 1'b0;
            host.wr(8'h4c, 32'hffffbfff);
            rdc(8'h4c, misc_exp(d[13:8], 0, 0, 0, 0));
            chk(32'({misc, sel}), 32'({d[13:8], {2{d[13]}}}));
        end
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        rdc(8'h4f, 32'h0);
        rdc(8'h4c, 32'h0f);
        present <= 1'b1;
        busy <= 1'b1;
        handle <= 1'b1;
        err <= 1'b1;
        @(posedge core_clk_i);
        err <= 1'b0;
        cyc(6);
        rdc(8'h4c, misc_exp(6'h0f, 1, 1, 1, 1));
        host.wr(8'h4c, 32'h0);
        rdc(8'h4c, misc_exp(6'h0f, 1, 1, 1, 1));
        host.wr(8'h4c, 32'h4000);
        {present, busy, handle} <= 3'h0;
        cyc(6);
        rdc(8'h4c, 32'h0f);
        // Error pulse beside a clearing write: the new error must survive
        fork
            host.wr(8'h4c, 32'h4000);
            begin
                @(posedge core_clk_i);
                err <= 1'b1;
                @(posedge core_clk_i);
                err <= 1'b0;
            end
        join
        rdc(8'h4c, 32'h400f);
        // Pins low but not selected as interrupt inputs
        chk(32'({f3, f2}), 32'h0);
        {pin2, pin3} <= 2'h3;
        cyc(8);
        host.wr(8'h44, 32'h0c);
        cyc(8);
        chk(32'({f3, f2}), 32'h0);
        pin2 <= 1'b0;
        cyc(8);
        rdc(8'h40, 32'h08000000);
        pin2 <= 1'b1;
        cyc(8);
        host.wr(8'h40, 32'h18000000);
        host.wr(8'h48, 32'h0c);
        pin3 <= 1'b0;
        cyc(8);
        rdc(8'h40, 32'h10000000);
        host.wr(8'h40, 32'h10000000);
        cyc(8);
        rdc(8'h40, 32'h0);
        pin2 <= 1'b0;
        cyc(8);
        rdc(8'h40, 32'h08000000);
        conclude();
    end
endmodule
